// ---- src/bnl_pkg.sv ----
// shared constants and types of the bitwise complement / or execute unit
package bnl_pkg;
  localparam int unsigned BNL_WORD_W = 32;
  localparam int unsigned BNL_IMM_W = 16;
  localparam int unsigned BNL_ADDR_W = 24;
  localparam int unsigned BNL_REGNUM_W = 5;
  localparam int unsigned BNL_REG_COUNT = 28;
  localparam logic [4:0] BNL_REG_MAX = 5'h1B;
  localparam logic [4:0] BNL_PAIR_REG_MAX = 5'h07;
  // general addressing field of the two-operand or
  localparam logic [1:0] BNL_G_REG = 2'h0;
  localparam logic [1:0] BNL_G_DIRECT = 2'h1;
  localparam logic [1:0] BNL_G_INDIRECT = 2'h2;
  localparam logic [1:0] BNL_G_IMM = 2'h3;
  // three-operand mode field: bit 0 picks memory for src1, bit 1 for src2
  localparam int unsigned BNL_T_SRC1_MEM_BIT = 0;
  localparam int unsigned BNL_T_SRC2_MEM_BIT = 1;
  localparam logic [31:0] BNL_WORD_ZERO = 32'h0000_0000;
  localparam logic [23:0] BNL_ADDR_ZERO = 24'h00_0000;
  localparam logic [4:0] BNL_REGNUM_ZERO = 5'h00;
  // status vector order: {luf, lv, uf, n, z, v, c}
  localparam int unsigned BNL_ST_C = 0;
  localparam int unsigned BNL_ST_V = 1;
  localparam int unsigned BNL_ST_Z = 2;
  localparam int unsigned BNL_ST_N = 3;
  localparam int unsigned BNL_ST_UF = 4;
  localparam int unsigned BNL_ST_LV = 5;
  localparam int unsigned BNL_ST_LUF = 6;
  localparam logic [6:0] BNL_STATUS_RESET = 7'h00;
  typedef enum logic [1:0] {
    BNL_OP_NOT_STORE,
    BNL_OP_OR2,
    BNL_OP_OR3,
    BNL_OP_NONE
  } bnl_op_t;
endpackage : bnl_pkg

// ---- src/bnl_logic_unit.sv ----
// execute-stage unit for complement with parallel store, two-operand or, three-operand or
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// What this block does
// - complement and parallel integer store happen together in one execute cycle
// - paired sources sampled at cycle start, destinations written at cycle end
// - store reads the register value from before the complement writes it
// - same memory source and store address: source read before memory write
// - n is result msb, z set on zero, v and uf cleared, others kept
// - saturation mode bit never changes result or flags
// - two-operand or source: 00 reg, 01 direct, 10 indirect, 11 immediate
// - immediate source is zero-extended to a full word before the or
// - or destinations are registers 0 to 27
// - three-operand src1 is register for mode 00/10, indirect for 01/11
// - paired form: memory operands indirect, registers limited to 0 to 7
// - complement inverts every source bit and writes the destination register
// -----------------------------------------------------------------------------
module bnl_logic_unit
  import bnl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic issue,
  input wire bnl_op_t op,
  input wire logic [1:0] g_mode,
  input wire logic [1:0] t_mode,
  input wire logic [4:0] dst_reg,
  input wire logic [4:0] src1_reg,
  input wire logic [4:0] src2_reg,
  input wire logic [4:0] store_src_reg,
  input wire logic [15:0] imm,
  input wire logic [31:0] mem_src1_data,
  input wire logic [31:0] mem_src2_data,
  input wire logic [23:0] store_addr,
  input wire logic saturation_mode_bit,
  input wire logic load_valid,
  input wire logic [4:0] load_reg,
  input wire logic [31:0] load_data,
  input wire logic status_load,
  input wire logic [6:0] status_in,
  output logic done,
  output logic illegal,
  output logic [31:0] result,
  output logic [4:0] result_reg,
  output logic mem_wr,
  output logic [23:0] mem_wr_addr,
  output logic [31:0] mem_wr_data,
  output logic [6:0] status
);

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  // operand pick for three-operand sources: memory when the mode bit is set
  function automatic logic [31:0] bnl_pick(input logic mem_sel, input logic [31:0] mem_val,
                                           input logic [31:0] reg_val);
    bnl_pick = mem_sel ? mem_val : reg_val;
  endfunction : bnl_pick

  // register number range check shared by every destination and source
  function automatic logic bnl_in_range(input logic [4:0] num, input logic [4:0] max);
    bnl_in_range = (num <= max);
  endfunction : bnl_in_range

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [31:0] regs [BNL_REG_COUNT];
  logic [31:0] next_regs [BNL_REG_COUNT];
  logic next_done;
  logic next_illegal;
  logic [31:0] next_result;
  logic [4:0] next_result_reg;
  logic next_mem_wr;
  logic [23:0] next_mem_wr_addr;
  logic [31:0] next_mem_wr_data;
  logic [6:0] next_status;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] alu_out;
  logic legal;

  // -------------------------------------------------------------------------
  // execute
  // -------------------------------------------------------------------------
  // all reads use the flop contents, so every source is the value at cycle start
  always_comb begin
    next_regs = regs;
    next_done = 1'b0;
    next_illegal = 1'b0;
    next_result = result;
    next_result_reg = result_reg;
    next_mem_wr = 1'b0;
    next_mem_wr_addr = mem_wr_addr;
    next_mem_wr_data = mem_wr_data;
    next_status = status;
    op_a = BNL_WORD_ZERO;
    op_b = BNL_WORD_ZERO;
    alu_out = BNL_WORD_ZERO;
    legal = 1'b0;
    // preload from the rest of the processor; an issued write below overrides it
    if (load_valid && bnl_in_range(load_reg, BNL_REG_MAX)) begin
      next_regs[load_reg] = load_data;
    end
    if (status_load) begin
      next_status = status_in;
    end
    if (issue) begin
      case (op)
        BNL_OP_NOT_STORE: begin
          // memory source only; register fields confined to 0..7
          legal = bnl_in_range(dst_reg, BNL_PAIR_REG_MAX) &&
                  bnl_in_range(store_src_reg, BNL_PAIR_REG_MAX);
          alu_out = ~mem_src2_data;
        end
        BNL_OP_OR2: begin
          legal = bnl_in_range(dst_reg, BNL_REG_MAX) &&
                  ((g_mode != BNL_G_REG) || bnl_in_range(src2_reg, BNL_REG_MAX));
          op_a = regs[dst_reg];
          case (g_mode)
            BNL_G_REG: op_b = regs[src2_reg];
            BNL_G_DIRECT: op_b = mem_src2_data;
            BNL_G_INDIRECT: op_b = mem_src2_data;
            BNL_G_IMM: op_b = {{(BNL_WORD_W - BNL_IMM_W){1'b0}}, imm};
            default: op_b = BNL_WORD_ZERO;
          endcase
          alu_out = op_a | op_b;
        end
        BNL_OP_OR3: begin
          legal = bnl_in_range(dst_reg, BNL_REG_MAX) &&
                  (t_mode[BNL_T_SRC1_MEM_BIT] || bnl_in_range(src1_reg, BNL_REG_MAX)) &&
                  (t_mode[BNL_T_SRC2_MEM_BIT] || bnl_in_range(src2_reg, BNL_REG_MAX));
          op_a = bnl_pick(t_mode[BNL_T_SRC1_MEM_BIT], mem_src1_data, regs[src1_reg]);
          op_b = bnl_pick(t_mode[BNL_T_SRC2_MEM_BIT], mem_src2_data, regs[src2_reg]);
          alu_out = op_a | op_b;
        end
        default: begin
          legal = 1'b0;
        end
      endcase
      // saturation mode never enters here on purpose
      if (legal) begin
        next_done = 1'b1;
        next_result = alu_out;
        next_result_reg = dst_reg;
        next_regs[dst_reg] = alu_out;
        next_status[BNL_ST_N] = alu_out[BNL_WORD_W-1];
        next_status[BNL_ST_Z] = (alu_out == BNL_WORD_ZERO);
        next_status[BNL_ST_V] = 1'b0;
        next_status[BNL_ST_UF] = 1'b0;
        if (op == BNL_OP_NOT_STORE) begin
          // store data from the pre-write flop, so a clash sees the old value
          next_mem_wr = 1'b1;
          next_mem_wr_addr = store_addr;
          next_mem_wr_data = regs[store_src_reg];
        end
      end else begin
        next_illegal = 1'b1;
      end
    end
  end

  // memory source was consumed this cycle; the write only leaves at the edge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < BNL_REG_COUNT; i++) begin
        regs[i] <= BNL_WORD_ZERO;
      end
      done <= 1'b0;
      illegal <= 1'b0;
      result <= BNL_WORD_ZERO;
      result_reg <= BNL_REGNUM_ZERO;
      mem_wr <= 1'b0;
      mem_wr_addr <= BNL_ADDR_ZERO;
      mem_wr_data <= BNL_WORD_ZERO;
      status <= BNL_STATUS_RESET;
    end else begin
      regs <= next_regs;
      done <= next_done;
      illegal <= next_illegal;
      result <= next_result;
      result_reg <= next_result_reg;
      mem_wr <= next_mem_wr;
      mem_wr_addr <= next_mem_wr_addr;
      mem_wr_data <= next_mem_wr_data;
      status <= next_status;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  store_pairing_a: assert property (@(posedge clock) disable iff (!reset_n)
    mem_wr |-> done) else $error("store without complement");

  store_old_value_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && op == BNL_OP_NOT_STORE && legal) |=> mem_wr_data == $past(regs[store_src_reg]))
    else $error("store did not use pre-write register value");

  store_addr_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && op == BNL_OP_NOT_STORE && legal) |=> mem_wr && mem_wr_addr == $past(store_addr))
    else $error("store address or strobe wrong");

  flag_update_a: assert property (@(posedge clock) disable iff (!reset_n)
    (done && !$past(status_load)) |-> status[BNL_ST_N] == result[BNL_WORD_W-1] &&
      status[BNL_ST_Z] == (result == BNL_WORD_ZERO) && !status[BNL_ST_V] && !status[BNL_ST_UF])
    else $error("n z v uf flags wrong");

  flags_kept_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && !status_load) |=> status[BNL_ST_C] == $past(status[BNL_ST_C]) &&
      status[BNL_ST_LV] == $past(status[BNL_ST_LV]) && status[BNL_ST_LUF] == $past(status[BNL_ST_LUF]))
    else $error("carry or latched flags disturbed");

  imm_zero_ext_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && op == BNL_OP_OR2 && g_mode == BNL_G_IMM && legal) |=>
      result == ($past(regs[dst_reg]) | {{(BNL_WORD_W - BNL_IMM_W){1'b0}}, $past(imm)}))
    else $error("immediate not zero-extended");

  dest_range_a: assert property (@(posedge clock) disable iff (!reset_n)
    done |-> result_reg <= BNL_REG_MAX) else $error("destination beyond register 27");

  // expectation rebuilt from the raw sources, not from the internal operand nets
  or3_result_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && op == BNL_OP_OR3 && legal) |=>
      result == ($past(t_mode[BNL_T_SRC1_MEM_BIT] ? mem_src1_data : regs[src1_reg]) |
                 $past(t_mode[BNL_T_SRC2_MEM_BIT] ? mem_src2_data : regs[src2_reg])))
    else $error("three-operand or result wrong");

  pair_range_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && op == BNL_OP_NOT_STORE && dst_reg > BNL_PAIR_REG_MAX) |=> illegal && !done)
    else $error("paired form accepted register above 7");

  not_result_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && op == BNL_OP_NOT_STORE && legal) |=> result == ~$past(mem_src2_data))
    else $error("complement result wrong");

  single_cycle_a: assert property (@(posedge clock) disable iff (!reset_n)
    (issue && op != BNL_OP_NONE) |=> (done ^ illegal))
    else $error("instruction did not finish in one cycle");

endmodule : bnl_logic_unit
`default_nettype wire

// ---- dv/bnl_mem_model.sv ----
// data memory model standing beside the logic unit
`timescale 1ns/1ps
`default_nettype none
module bnl_mem_model (
  input wire logic clock,
  input wire logic wr,
  input wire logic [23:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [16];
  // distinct seed contents, location 0 holds 0C2F
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'h0000_0C2F * (i + 1);
    end
  end
  // read is combinational, write lands on the edge: a same-address read sees old data
  assign rd_data = mem[rd_addr];
  // only the low address bits are decoded, enough for the bench
  always @(posedge clock) begin
    if (wr) begin
      mem[wr_addr[3:0]] <= wr_data;
    end
  end
endmodule : bnl_mem_model
`default_nettype wire

// ---- dv/bitwise_not_or_logic_unit_bench.sv ----
// self-checking bench for the complement / or execute unit
`timescale 1ns/1ps
`default_nettype none
module bitwise_not_or_logic_unit_bench import bnl_pkg::*;;
  logic clock, reset_n, issue, saturation_mode_bit, load_valid, status_load, done, illegal, mem_wr;
  bnl_op_t op;
  logic [1:0] g_mode, t_mode;
  logic [4:0] dst_reg, src1_reg, src2_reg, store_src_reg, load_reg, result_reg;
  logic [15:0] imm;
  logic [31:0] mem_src1_data, mem_src2_data, load_data, result, mem_wr_data, rr;
  logic [23:0] store_addr, mem_wr_addr;
  logic [6:0] status_in, status, st;
  logic [3:0] rd_addr;
  logic [31:0] regs [28];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'h6c67;

  bnl_logic_unit u_dut (.clock, .reset_n, .issue, .op, .g_mode, .t_mode, .dst_reg, .src1_reg, .src2_reg,
    .store_src_reg, .imm, .mem_src1_data, .mem_src2_data, .store_addr, .saturation_mode_bit, .load_valid,
    .load_reg, .load_data, .status_load, .status_in, .done, .illegal, .result, .result_reg, .mem_wr,
    .mem_wr_addr, .mem_wr_data, .status);
  bnl_mem_model u_mem (.clock, .wr(mem_wr), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data), .rd_addr,
    .rd_data(mem_src2_data));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // flags after a logic op: n from msb, z on zero, v and uf cleared, c lv luf kept
  function automatic logic [6:0] exp_status(input logic [6:0] s, input logic [31:0] r);
    exp_status = {s[6:5], 1'b0, r[31], r == 32'h0, 1'b0, s[0]};
  endfunction : exp_status

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // one instruction; issue stays high so callers run back to back
  task automatic exe(input bnl_op_t o, input logic [1:0] g, input logic [1:0] t, input logic [4:0] d,
                     input logic [4:0] s1, input logic [4:0] s2, input logic [4:0] ss,
                     input logic [15:0] im, input logic [3:0] a);
    logic bad;
    logic [31:0] x, y, r, old;
    op = o;
    {g_mode, t_mode, dst_reg, src1_reg, src2_reg, store_src_reg, imm, rd_addr} = {g, t, d, s1, s2, ss, im, a};
    store_addr = {20'h0_0000, a};
    mem_src1_data = $random(seed);
    saturation_mode_bit = $random(seed);
    issue = 1'b1;
    #1;
    old = regs[ss];
    r = 32'h0;
    case (o)
      BNL_OP_NOT_STORE: begin
        bad = d > BNL_PAIR_REG_MAX || ss > BNL_PAIR_REG_MAX;
        r = ~mem_src2_data;
      end
      BNL_OP_OR2: begin
        y = (g == BNL_G_REG) ? regs[s2] : (g == BNL_G_IMM) ? {16'h0000, im} : mem_src2_data;
        bad = d > BNL_REG_MAX || (g == BNL_G_REG && s2 > BNL_REG_MAX);
        r = regs[d] | y;
      end
      BNL_OP_OR3: begin
        x = t[0] ? mem_src1_data : regs[s1];
        y = t[1] ? mem_src2_data : regs[s2];
        bad = d > BNL_REG_MAX || (!t[0] && s1 > BNL_REG_MAX) || (!t[1] && s2 > BNL_REG_MAX);
        r = x | y;
      end
      default: bad = 1'b1;
    endcase
    @(posedge clock);
    #1;
    chk({done, illegal}, {!bad, bad});
    if (!bad) begin
      st = exp_status(st, r);
      regs[d] = r;
      chk(result, r);
      chk(result_reg, d);
    end
    chk(status, st);
    chk(mem_wr, !bad && o == BNL_OP_NOT_STORE);
    if (!bad && o == BNL_OP_NOT_STORE) begin
      chk(mem_wr_addr, {20'h0_0000, a});
      chk(mem_wr_data, old);
    end
  endtask : exe

  // reset, preload, corner cases, then random traffic
  initial begin
    {reset_n, issue, saturation_mode_bit, load_valid, status_load, load_reg, load_data, status_in} = '0;
    {g_mode, t_mode, dst_reg, src1_reg, src2_reg, store_src_reg, imm, rd_addr, mem_src1_data} = '0;
    op = BNL_OP_NONE;
    store_addr = 24'h00_0000;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    chk(status, 32'h0);
    for (int i = 0; i < 28; i++) begin
      load_valid = 1'b1;
      load_reg = i[4:0];
      load_data = (i == 7) ? 32'h0000_00DC : $random(seed);
      regs[i] = load_data;
      @(posedge clock);
      #1;
    end
    load_valid = 1'b0;
    status_load = 1'b1;
    status_in = 7'h61;
    st = 7'h61;
    @(posedge clock);
    #1;
    status_load = 1'b0;
    exe(BNL_OP_NOT_STORE, 2'h0, 2'h0, 5'h03, 5'h00, 5'h00, 5'h07, 16'h0000, 4'h0);
    // fixed values: complement of the seeded word, store of the preloaded register
    chk(result, 32'hFFFF_F3D0);
    chk(mem_wr_data, 32'h0000_00DC);
    exe(BNL_OP_NOT_STORE, 2'h0, 2'h0, 5'h05, 5'h00, 5'h00, 5'h05, 16'h0000, 4'h0);
    // same address: this read saw the old word, the earlier store has now landed
    chk(result, 32'hFFFF_F3D0);
    chk(u_mem.mem[0], 32'h0000_00DC);
    exe(BNL_OP_NOT_STORE, 2'h0, 2'h0, 5'h08, 5'h00, 5'h00, 5'h01, 16'h0000, 4'h2);
    exe(BNL_OP_OR2, BNL_G_IMM, 2'h0, 5'h02, 5'h00, 5'h00, 5'h00, 16'hFFFF, 4'h0);
    exe(BNL_OP_OR3, 2'h0, 2'h3, 5'h1B, 5'h1C, 5'h1F, 5'h00, 16'h0000, 4'h3);
    exe(BNL_OP_OR3, 2'h0, 2'h0, 5'h1C, 5'h00, 5'h01, 5'h00, 16'h0000, 4'h3);
    exe(BNL_OP_NONE, 2'h0, 2'h0, 5'h01, 5'h00, 5'h01, 5'h00, 16'h0000, 4'h3);
    repeat (600) begin
      rr = $random(seed);
      exe(bnl_op_t'(rr[1:0]), rr[3:2], rr[5:4], rr[30] ? rr[10:6] : {2'h0, rr[8:6]}, rr[15:11], rr[20:16],
          rr[31] ? rr[27:23] : {2'h0, rr[25:23]}, rr[31:16], rr[29:26]);
    end
    issue = 1'b0;
    @(posedge clock);
    #1;
    complete_run();
  end
endmodule : bitwise_not_or_logic_unit_bench
`default_nettype wire
